/* src/frmc_pkg.sv */
package frmc_pkg;
	localparam int INT_W      = 12;
	localparam int FRAC_MSB_W = 12;
	localparam int FRAC_LSB_W = 13;
	localparam int FRAC_W     = 25;
	localparam int N_W        = INT_W + FRAC_W;
	localparam int HOP_W      = 16;
	localparam int SHIFT_W    = 4;
	localparam int TMR_W      = 12;
	localparam int IVL_W      = 24;
	localparam int STEP_W     = 20;
	localparam int RDIV_W     = 5;
	localparam int CELL_W     = 3;
	localparam logic [CELL_W-1:0] CELL_MAX = 3'h7;
	localparam int PFD_MAX_MHZ = 32;
	typedef enum logic [1:0] {
		FRMC_SINGLE_RAMP  = 2'h0,
		FRMC_SINGLE_SAW   = 2'h1,
		FRMC_SAW_RAMP     = 2'h2,
		FRMC_TRIANGLE     = 2'h3
	} frmc_wave_e;
	typedef enum logic [1:0] {
		FRMC_IDLE = 2'h0,
		FRMC_RUN  = 2'h1,
		FRMC_END  = 2'h2,
		FRMC_HOLD = 2'h3
	} frmc_state_e;
endpackage

/* src/frmc_core.sv */
`timescale 1ns/100ps
// Behaviour
// - Fraction is 12-bit upper field above 13-bit lower field.
// - Phase-detector rate is reference times doubler, over divider, over halver.
// - Each imminent slip adds one extra charge pump cell while assist active.
// - After overshoot, extra cells switch off one at a time to zero.
// - At most seven extra cells enabled at once.
// - Slip assist works only while its enable bit is set.
// - FSK moves divide value by hop word shifted by hop shift while ramp idle.
// - PSK sets output phase 0 or 180 from trigger pin level.
// - Four waveforms: single ramp, single sawtooth, sawtooth, triangle.
// - Step interval is prescale times multiplier phase-detector periods.
// - 20-bit step count sets hops before waveform end action.
// - Single ramp adds shifted hop per interval, then holds final value.
// - Single sawtooth restores start value one interval after steps, then holds.
// - Sawtooth repeats single sawtooth until ramp disabled.
// - Triangle alternates add and subtract after each completed step count.
// - Two-bit mode field selects the ramp waveform.
// - Hop word select chooses which of two hop words a write loads.
module frmc_core (
	// Clock and reset
	input  wire logic                                 i_core_clk,
	input  wire logic                                 i_rst_n,
	// Divide value
	input  wire logic [frmc_pkg::INT_W-1:0]           i_int_value,
	input  wire logic [frmc_pkg::FRAC_MSB_W-1:0]      i_frac_msb,
	input  wire logic [frmc_pkg::FRAC_LSB_W-1:0]      i_frac_lsb,
	// Reference path
	input  wire logic                                 i_ref_doubler,
	input  wire logic                                 i_ref_halver,
	input  wire logic [frmc_pkg::RDIV_W-1:0]          i_ref_div,
	// Modulation
	input  wire logic                                 i_fsk_enable,
	input  wire logic                                 i_psk_enable,
	input  wire logic                                 i_mod_trigger,
	// Hop word loading
	input  wire logic                                 i_hop_write,
	input  wire logic                                 i_hop_word_select,
	input  wire logic [frmc_pkg::HOP_W-1:0]           i_hop_size_word,
	input  wire logic [frmc_pkg::SHIFT_W-1:0]         i_hop_size_shift,
	// Ramp
	input  wire logic                                 i_ramp_enable,
	input  wire logic [1:0]                           i_ramp_mode,
	input  wire logic [frmc_pkg::TMR_W-1:0]           i_ramp_prescale_count,
	input  wire logic [frmc_pkg::TMR_W-1:0]           i_ramp_timer_multiplier,
	input  wire logic [frmc_pkg::STEP_W-1:0]          i_step_count,
	// Slip assist
	input  wire logic                                 i_slip_assist_enable,
	input  wire logic                                 i_slip_imminent,
	input  wire logic                                 i_freq_passed,
	// Outputs
	output logic      [frmc_pkg::N_W-1:0]             o_divide_value,
	output logic                                      o_phase_invert,
	output logic      [frmc_pkg::CELL_W-1:0]          o_extra_cells,
	output logic      [frmc_pkg::RDIV_W+1:0]          o_pfd_mult,
	output logic      [frmc_pkg::RDIV_W:0]            o_pfd_div,
	output logic                                      o_ramp_busy
);
	localparam int N_W = frmc_pkg::N_W;

	// Trigger pin synchroniser
	logic trig_s1_q;
	logic trig_s2_q;
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			trig_s1_q <= 1'b0;
			trig_s2_q <= 1'b0;
		end else begin
			trig_s1_q <= i_mod_trigger;
			trig_s2_q <= trig_s1_q;
		end
	end

	// Hop word banks
	logic [frmc_pkg::HOP_W-1:0]   hop_word_q  [2];
	logic [frmc_pkg::SHIFT_W-1:0] hop_shift_q [2];
	logic [frmc_pkg::HOP_W-1:0]   hop_word_d  [2];
	logic [frmc_pkg::SHIFT_W-1:0] hop_shift_d [2];
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_hop
			always_comb begin
				hop_word_d[gi]  = hop_word_q[gi];
				hop_shift_d[gi] = hop_shift_q[gi];
				if (i_hop_write && (i_hop_word_select == 1'(gi))) begin
					hop_word_d[gi]  = i_hop_size_word;
					hop_shift_d[gi] = i_hop_size_shift;
				end
			end
			always_ff @(posedge i_core_clk or negedge i_rst_n) begin
				if (!i_rst_n) begin
					hop_word_q[gi]  <= '0;
					hop_shift_q[gi] <= '0;
				end else begin
					hop_word_q[gi]  <= hop_word_d[gi];
					hop_shift_q[gi] <= hop_shift_d[gi];
				end
			end
		end
	endgenerate

	// Signed hop step, sign-extended then shifted
	logic [N_W-1:0] hop_step;
	logic [N_W-1:0] base_n;
	always_comb begin
		hop_step = {{(N_W-frmc_pkg::HOP_W){hop_word_q[0][frmc_pkg::HOP_W-1]}}, hop_word_q[0]} << hop_shift_q[0];
		base_n = {i_int_value, i_frac_msb, i_frac_lsb};
	end

	// Ramp sequencer
	frmc_pkg::frmc_state_e state_q, state_d;
	logic [N_W-1:0]                   ramp_n_q, ramp_n_d;
	logic [frmc_pkg::IVL_W-1:0]       tmr_q, tmr_d;
	logic [frmc_pkg::STEP_W-1:0]      steps_q, steps_d;
	logic                             down_q, down_d;
	logic [frmc_pkg::IVL_W-1:0]       interval;
	logic                             tick;
	always_comb begin
		interval = i_ramp_prescale_count * i_ramp_timer_multiplier;
		tick    = (tmr_q + 24'h000001 >= interval);
		tmr_d   = tick ? '0 : tmr_q + 24'h000001;
		state_d = state_q;
		ramp_n_d = ramp_n_q;
		steps_d = steps_q;
		down_d  = down_q;
		unique case (state_q)
			frmc_pkg::FRMC_IDLE: begin
				tmr_d    = '0;
				ramp_n_d = base_n;
				steps_d  = '0;
				down_d   = 1'b0;
				if (i_ramp_enable)
					state_d = frmc_pkg::FRMC_RUN;
			end
			frmc_pkg::FRMC_RUN: begin
				if (tick) begin
					ramp_n_d = down_q ? ramp_n_q - hop_step : ramp_n_q + hop_step;
					steps_d  = steps_q + 20'h00001;
					if (steps_q + 20'h00001 >= i_step_count) begin
						steps_d = '0;
						unique case (frmc_pkg::frmc_wave_e'(i_ramp_mode))
							frmc_pkg::FRMC_SINGLE_RAMP: state_d = frmc_pkg::FRMC_HOLD;
							frmc_pkg::FRMC_SINGLE_SAW:  state_d = frmc_pkg::FRMC_END;
							frmc_pkg::FRMC_SAW_RAMP:    state_d = frmc_pkg::FRMC_END;
							frmc_pkg::FRMC_TRIANGLE:    down_d  = ~down_q;
						endcase
					end
				end
			end
			frmc_pkg::FRMC_END: begin
				if (tick) begin
					ramp_n_d = base_n;
					state_d  = (frmc_pkg::frmc_wave_e'(i_ramp_mode) == frmc_pkg::FRMC_SAW_RAMP) ?
						frmc_pkg::FRMC_RUN : frmc_pkg::FRMC_HOLD;
				end
			end
			frmc_pkg::FRMC_HOLD: begin
				tmr_d = '0;
			end
		endcase
		if (!i_ramp_enable)
			state_d = frmc_pkg::FRMC_IDLE;
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q  <= frmc_pkg::FRMC_IDLE;
			ramp_n_q <= '0;
			tmr_q    <= '0;
			steps_q  <= '0;
			down_q   <= 1'b0;
		end else begin
			state_q  <= state_d;
			ramp_n_q <= ramp_n_d;
			tmr_q    <= tmr_d;
			steps_q  <= steps_d;
			down_q   <= down_d;
		end
	end

	// Slip assist cell count
	logic [frmc_pkg::CELL_W-1:0] cells_q, cells_d;
	logic                        passed_q, passed_d;
	always_comb begin
		cells_d  = cells_q;
		passed_d = passed_q;
		if (!i_slip_assist_enable) begin
			cells_d  = '0;
			passed_d = 1'b0;
		end else if (passed_q || i_freq_passed) begin
			passed_d = (cells_q > 3'h1);
			if (cells_q != 3'h0)
				cells_d = cells_q - 3'h1;
		// add a cell; cap at seven
		end else if (i_slip_imminent && cells_q != frmc_pkg::CELL_MAX) begin
			cells_d = cells_q + 3'h1;
		end
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			cells_q  <= '0;
			passed_q <= 1'b0;
		end else begin
			cells_q  <= cells_d;
			passed_q <= passed_d;
		end
	end

	// Output stage
	logic [N_W-1:0]                divide_d;
	logic [frmc_pkg::RDIV_W+1:0]   mult_d;
	logic [frmc_pkg::RDIV_W:0]     div_d;
	always_comb begin
		divide_d = (state_q == frmc_pkg::FRMC_IDLE) ? base_n : ramp_n_q;
		if (i_fsk_enable && state_q == frmc_pkg::FRMC_IDLE)
			divide_d = trig_s2_q ? base_n + hop_step : base_n - hop_step;
		mult_d = i_ref_doubler ? 7'h02 : 7'h01;
		div_d  = i_ref_halver ? {i_ref_div, 1'b0} : {1'b0, i_ref_div};
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_divide_value <= '0;
			o_phase_invert <= 1'b0;
			o_extra_cells  <= '0;
			o_pfd_mult     <= '0;
			o_pfd_div      <= '0;
			o_ramp_busy    <= 1'b0;
		end else begin
			o_divide_value <= divide_d;
			o_phase_invert <= i_psk_enable & trig_s2_q;
			o_extra_cells  <= cells_d;
			o_pfd_mult     <= mult_d;
			o_pfd_div      <= div_d;
			o_ramp_busy    <= (state_d == frmc_pkg::FRMC_RUN) || (state_d == frmc_pkg::FRMC_END);
		end
	end
endmodule

/* tb/frmc_core_assertions.sv */
`timescale 1ns/100ps
module frmc_core_checker (
	input wire logic i_core_clk, i_rst_n, i_ref_doubler, i_ref_halver, i_psk_enable, i_mod_trigger,
	input wire logic i_fsk_enable, i_ramp_enable, i_slip_assist_enable, i_slip_imminent, o_phase_invert, o_ramp_busy,
	input wire logic [11:0] i_int_value, i_frac_msb, i_ramp_prescale_count, i_ramp_timer_multiplier,
	input wire logic [12:0] i_frac_lsb,
	input wire logic [4:0]  i_ref_div,
	input wire logic [36:0] o_divide_value,
	input wire logic [2:0]  o_extra_cells,
	input wire logic [6:0]  o_pfd_mult,
	input wire logic [5:0]  o_pfd_div
);
	default clocking dc @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);
	logic [36:0] prev_q;
	logic [23:0] gap_q, gap_d;
	logic        seen_q, seen_d, chg;
	// Set once an edge has passed outside reset
	logic        live_q;
	// Cycles since the divide value last moved
	always_comb begin
		chg = o_divide_value != prev_q;
		gap_d = chg ? 24'h1 : gap_q + 24'h1;
		seen_d = o_ramp_busy & (seen_q | chg);
	end
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			prev_q <= '0;
			gap_q <= '0;
			seen_q <= 1'b0;
			live_q <= 1'b0;
		end else begin
			prev_q <= o_divide_value;
			gap_q <= gap_d;
			seen_q <= seen_d;
			live_q <= 1'b1;
		end
	end
	property p_base; (!i_ramp_enable && !i_fsk_enable && $stable({i_int_value, i_frac_msb, i_frac_lsb}))[*3]
		|-> o_divide_value == {i_int_value, i_frac_msb, i_frac_lsb}; endproperty
	a_base: assert property (p_base) else $error("divide value not base");
	property p_pfd; live_q |-> o_pfd_mult == 7'h1 + $past(i_ref_doubler)
		&& o_pfd_div == {1'b0, $past(i_ref_div)} << $past(i_ref_halver); endproperty
	a_pfd: assert property (p_pfd) else $error("pfd ratio wrong");
	property p_up; o_extra_cells > $past(o_extra_cells)
		|-> o_extra_cells == $past(o_extra_cells) + 3'h1 && $past(i_slip_imminent); endproperty
	a_up: assert property (p_up) else $error("cell added wrongly");
	property p_down; $past(i_slip_assist_enable) && o_extra_cells < $past(o_extra_cells)
		|-> o_extra_cells == $past(o_extra_cells) - 3'h1; endproperty
	a_down: assert property (p_down) else $error("cells not dropped singly");
	property p_cap; $past(i_slip_assist_enable) && $past(o_extra_cells) == 3'h7 |-> o_extra_cells != 3'h0; endproperty
	a_cap: assert property (p_cap) else $error("cell count wrapped");
	property p_gate; !i_slip_assist_enable |=> o_extra_cells == 3'h0; endproperty
	a_gate: assert property (p_gate) else $error("cell added while disabled");
	property p_psk; (i_psk_enable && $stable(i_mod_trigger))[*4] |-> o_phase_invert == i_mod_trigger; endproperty
	a_psk: assert property (p_psk) else $error("phase not following trigger");
	property p_gap; o_ramp_busy && seen_q && chg |-> gap_q == i_ramp_prescale_count * i_ramp_timer_multiplier;
	endproperty
	a_gap: assert property (p_gap) else $error("step interval wrong");
endmodule
bind frmc_core frmc_core_checker u_chk (.*);

/* tb/frmc_host_model.sv */
`timescale 1ns/100ps
module frmc_host_model (
	input  wire logic  i_core_clk,
	input  wire logic  i_go,
	output logic       o_hop_write = 1'b0,
	output logic       o_hop_word_select = 1'b0,
	output logic [15:0] o_hop_size_word = 16'h0000,
	output logic [3:0] o_hop_size_shift = 4'h0
);
	// bank 0 first, then bank 1
	always @(posedge i_core_clk) begin
		if (i_go) begin
			o_hop_word_select <= 1'b0;
			o_hop_size_word <= 16'h0005;
			o_hop_size_shift <= 4'h2;
			o_hop_write <= 1'b1;
			@(posedge i_core_clk);
			o_hop_word_select <= 1'b1;
			o_hop_size_word <= 16'hfff0;
			@(posedge i_core_clk);
			o_hop_write <= 1'b0;
			o_hop_size_word <= 16'h000f;
		end
	end
endmodule

/* tb/test_frmc_core.sv */
`timescale 1ns/100ps
module test_frmc_core;
	localparam logic [36:0] D = 37'h14;
	logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_ref_doubler = 1'b0, i_ref_halver = 1'b0, go = 1'b0;
	logic i_fsk_enable = 1'b0, i_psk_enable = 1'b0, i_mod_trigger = 1'b0, i_ramp_enable = 1'b0;
	logic i_slip_assist_enable = 1'b0, i_slip_imminent = 1'b0, i_freq_passed = 1'b0, i_hop_write, i_hop_word_select;
	logic [11:0] i_int_value = 12'h244, i_frac_msb = 12'h051, i_ramp_prescale_count = 12'h002;
	logic [11:0] i_ramp_timer_multiplier = 12'h002;
	logic [12:0] i_frac_lsb = 13'h1d71;
	logic [4:0]  i_ref_div = 5'h05;
	logic [15:0] i_hop_size_word;
	logic [3:0]  i_hop_size_shift;
	logic [1:0]  i_ramp_mode = 2'h0;
	logic [19:0] i_step_count = 20'h00003;
	logic [36:0] o_divide_value, b, hi;
	logic [6:0]  o_pfd_mult;
	logic [5:0]  o_pfd_div;
	logic [2:0]  o_extra_cells;
	logic        o_phase_invert, o_ramp_busy;
	int          fails = 0, checks_done = 0;
	always #50 i_core_clk = ~i_core_clk;
	frmc_core dut (.*);
	frmc_host_model host (.i_core_clk(i_core_clk), .i_go(go), .o_hop_write(i_hop_write),
		.o_hop_word_select(i_hop_word_select), .o_hop_size_word(i_hop_size_word), .o_hop_size_shift(i_hop_size_shift));
	task automatic chk(input string nm, input logic [36:0] exp, got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask
	task automatic wait_val(input logic [36:0] v, input int n);
		for (int k = 0; k < n && o_divide_value !== v; k++) tick(1);
		chk("divide", v, o_divide_value);
		if (o_divide_value !== v) finish_test();
	endtask
	initial begin
		b = {i_int_value, i_frac_msb, i_frac_lsb};
		repeat (3) @(posedge i_core_clk);
		i_rst_n <= 1'b1;
		go <= 1'b1;
		@(posedge i_core_clk);
		go <= 1'b0;
		tick(4);
		chk("base", b, o_divide_value);
		for (int m = 0; m < 4; m++) begin
			@(posedge i_core_clk);
			{i_ref_doubler, i_ref_halver} <= 2'(m);
			tick(2);
			chk("pfd", 37'({m[1] ? 7'h2 : 7'h1, m[0] ? 6'h0a : 6'h05}), 37'({o_pfd_mult, o_pfd_div}));
		end
		for (int m = 0; m < 4; m++) begin
			@(posedge i_core_clk);
			i_ramp_mode <= 2'(m);
			@(posedge i_core_clk);
			i_ramp_enable <= 1'b1;
			tick(1);
			wait_val(b + 3 * D, 40);
			chk("busy", 37'(m != 0), 37'(o_ramp_busy));
			if (m == 3) begin
				wait_val(b + 2 * D, 6);
				wait_val(b, 12);
				wait_val(b + D, 6);
			end else if (m > 0) begin
				wait_val(b, 6);
				if (m == 2) wait_val(b + D, 6);
			end
			if (m < 2) begin
				tick(20);
				chk("hold", m ? b : b + 3 * D, o_divide_value);
			end
			@(posedge i_core_clk);
			i_ramp_enable <= 1'b0;
			tick(3);
			chk("idle", b, o_divide_value);
			chk("idle busy", 37'h0, 37'(o_ramp_busy));
		end
		@(posedge i_core_clk);
		i_fsk_enable <= 1'b1;
		i_mod_trigger <= 1'b1;
		tick(6);
		hi = o_divide_value;
		@(posedge i_core_clk);
		i_mod_trigger <= 1'b0;
		tick(6);
		chk("fsk", 2 * D, hi > o_divide_value ? hi - o_divide_value : o_divide_value - hi);
		@(posedge i_core_clk);
		i_fsk_enable <= 1'b0;
		i_psk_enable <= 1'b1;
		for (int t = 0; t < 2; t++) begin
			@(posedge i_core_clk);
			i_mod_trigger <= !t[0];
			tick(6);
			chk("phase", 37'(!t[0]), 37'(o_phase_invert));
		end
		@(posedge i_core_clk);
		i_psk_enable <= 1'b0;
		i_slip_imminent <= 1'b1;
		tick(4);
		chk("cells off", 37'h0, 37'(o_extra_cells));
		@(posedge i_core_clk);
		i_slip_assist_enable <= 1'b1;
		tick(12);
		chk("cells cap", 37'h7, 37'(o_extra_cells));
		@(posedge i_core_clk);
		i_slip_imminent <= 1'b0;
		i_freq_passed <= 1'b1;
		tick(12);
		chk("cells down", 37'h0, 37'(o_extra_cells));
		finish_test();
	end
endmodule
